// *** rtl/cim_pkg.sv ***
// constants, register map and function indices for the contact input mapper
package cim_pkg;

   // clock and power-system timing
   localparam int unsigned CLK_HZ           = 25_000_000;
   localparam int unsigned LINE_HZ          = 60;
   localparam int unsigned QUAL_LINE_CYCLES = 2;
   // least time rounds up to whole clock cycles
   localparam int unsigned QUAL_CLKS        =
      (CLK_HZ * QUAL_LINE_CYCLES + LINE_HZ - 1) / LINE_HZ;
   localparam int unsigned QUAL_CNT_W       = 20;
   localparam int unsigned BLINK_HALF_MS    = 500;
   localparam int unsigned BLINK_CLKS       = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam int unsigned BLINK_CNT_W      = 24;

   // sizes
   localparam int unsigned NUM_IN   = 6;
   localparam int unsigned NUM_FUNC = 17;
   localparam int unsigned NUM_ELEM = 16;
   localparam int unsigned DAY_W    = 5;

   // logical function indices
   localparam int unsigned F_BREAKER_CLOSED_AUX   = 0;
   localparam int unsigned F_BREAKER_OPEN_AUX     = 1;
   localparam int unsigned F_RECLOSE_ENABLE_INPUT = 2;
   localparam int unsigned F_PHASE_OC_SUPERVISE   = 3;
   localparam int unsigned F_GROUND_OC_SUPERVISE  = 4;
   localparam int unsigned F_NEG_SEQ_SUPERVISE    = 5;
   localparam int unsigned F_INST_LEVEL_ONE       = 6;
   localparam int unsigned F_INST_LEVEL_TWO       = 7;
   localparam int unsigned F_INST_LEVEL_THREE     = 8;
   localparam int unsigned F_TRIP_COIL_MONITOR    = 9;
   localparam int unsigned F_ZONE_SEQUENCE        = 10;
   localparam int unsigned F_SENSITIVE_EARTH      = 11;
   localparam int unsigned F_ALT_SETTINGS_ONE     = 12;
   localparam int unsigned F_ALT_SETTINGS_TWO     = 13;
   localparam int unsigned F_SINGLE_SHOT_RECLOSE  = 14;
   localparam int unsigned F_MULTI_SHOT_RECLOSE   = 15;
   localparam int unsigned F_USER_DISPLAY_INPUT   = 16;

   // functions that stay enabled while unmapped (sensitive earth bit only on that variant)
   localparam logic [NUM_FUNC-1:0] DFLT_ON_MASK  = 17'h00ff8;
   localparam logic [NUM_FUNC-1:0] EARTH_MASK    = 17'h00800;

   // factory mapping: inputs 1..3 closed-enable onto the breaker and reclose functions
   localparam logic [NUM_IN-1:0] DFLT_MAP_CLOSED  = 6'h01;
   localparam logic [NUM_IN-1:0] DFLT_MAP_OPEN    = 6'h02;
   localparam logic [NUM_IN-1:0] DFLT_MAP_RECLOSE = 6'h04;

   // register byte offsets
   localparam logic [7:0] REG_STATUS    = 8'h00;
   localparam logic [7:0] REG_FUNC      = 8'h04;
   localparam logic [7:0] REG_FORCE     = 8'h08;
   localparam logic [7:0] REG_TRIP_MASK = 8'h0c;
   localparam logic [7:0] REG_RTC_DAY   = 8'h10;
   localparam logic [7:0] REG_MAP_BASE  = 8'h40;

   // field positions
   localparam int unsigned MAP_LSB     = 0;
   localparam int unsigned POL_LSB     = 8;
   localparam int unsigned STAT_IN_LSB = 0;
   localparam int unsigned STAT_ALARM  = 8;
   localparam int unsigned STAT_RTC    = 9;
   localparam int unsigned STAT_BLINK  = 10;

   // reset values
   localparam logic [NUM_ELEM-1:0] RST_TRIP_MASK = 16'hffff;
   localparam logic [DAY_W-1:0]    RST_DAY       = 5'h01;
   localparam logic [NUM_FUNC-1:0] RST_FORCE     = 17'h00000;

endpackage : cim_pkg

// *** rtl/cim_contact_qual.sv ***
// synchroniser and change-of-state qualifier for one contact input
module cim_contact_qual
#(
   parameter int unsigned QUAL_CLKS_P = cim_pkg::QUAL_CLKS
)
(
   input  wire logic clk_i,      // processing clock
   input  wire logic rst_i,      // synchronous reset, active high
   input  wire logic contact_i,  // raw contact level, 1 = closed
   output logic      state_o     // qualified contact level
);
   import cim_pkg::*;

   localparam logic [QUAL_CNT_W-1:0] LAST = QUAL_CNT_W'(QUAL_CLKS_P - 1);

   logic                  sync1_ff;
   logic                  sync2_ff;
   logic                  state_ff;
   logic [QUAL_CNT_W-1:0] cnt_ff;
   logic                  nxt_state;
   logic [QUAL_CNT_W-1:0] nxt_cnt;

   // any bounce back to the held level restarts the count
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = '0;
      if (sync2_ff != state_ff)
      begin
         if (cnt_ff == LAST)
         begin
            nxt_state = sync2_ff;
         end
         else
         begin
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         state_ff <= 1'b0;
         cnt_ff   <= '0;
      end
      else
      begin
         sync1_ff <= contact_i;
         sync2_ff <= sync1_ff;
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign state_o = state_ff;

endmodule : cim_contact_qual

// *** rtl/cim_func_eval.sv ***
// combines the mapped, polarity-adjusted inputs into one logical function value
module cim_func_eval
(
   input  wire logic [cim_pkg::NUM_IN-1:0] map_i,   // inputs assigned to this function
   input  wire logic [cim_pkg::NUM_IN-1:0] pol_i,   // 1 = closed enables, 0 = open enables
   input  wire logic [cim_pkg::NUM_IN-1:0] qual_i,  // qualified contact levels
   input  wire logic                       dflt_i,  // value while unmapped
   output logic                            val_o    // function value
);
   import cim_pkg::*;

   logic [NUM_IN-1:0] term;

   always_comb
   begin
      term = ~map_i | ~(pol_i ^ qual_i);
      if (map_i == '0)
      begin
         val_o = dflt_i;
      end
      else
      begin
         val_o = &term;
      end
   end

endmodule : cim_func_eval

// *** rtl/cim_contact_input_mapper.sv ***
// contact input mapper: qualification, mapping, forcing, trip mask and wishbone registers
module cim_contact_input_mapper
#(
   parameter int unsigned QUAL_CLKS_P  = cim_pkg::QUAL_CLKS,   // contact qualify time
   parameter int unsigned BLINK_CLKS_P = cim_pkg::BLINK_CLKS,  // display half period
   parameter bit          EARTH_FITTED = 1'b1                  // earth-fault variant fitted
)
(
   input  wire logic                         clk_i,        // 25 MHz clock
   input  wire logic                         rst_i,        // synchronous reset
   input  wire logic [7:0]                   wb_adr_i,     // byte address
   input  wire logic [31:0]                  wb_dat_i,     // write data
   output logic      [31:0]                  wb_dat_o,     // read data
   input  wire logic                         wb_we_i,      // write enable
   input  wire logic [3:0]                   wb_sel_i,     // byte lanes
   input  wire logic                         wb_cyc_i,     // bus cycle
   input  wire logic                         wb_stb_i,     // strobe
   output logic                              wb_ack_o,     // acknowledge
   input  wire logic [cim_pkg::NUM_IN-1:0]   contact_i,    // raw contacts, 1 = closed
   input  wire logic [cim_pkg::NUM_ELEM-1:0] elem_trip_i,  // element trip requests
   output logic                              master_trip_o,              // master trip
   output logic      [cim_pkg::NUM_FUNC-1:0] func_o,                     // function values
   output logic                              trip_circuit_fail_alarm_o,  // coil alarm
   output logic                              user_display_blink_o,       // message visible
   output logic                              rtc_run_o                   // clock running
);
   import cim_pkg::*;

   localparam logic [BLINK_CNT_W-1:0] BLINK_LAST = BLINK_CNT_W'(BLINK_CLKS_P - 1);
   localparam logic [NUM_FUNC-1:0]    DFLT_ON    =
      EARTH_FITTED ? DFLT_ON_MASK : (DFLT_ON_MASK & ~EARTH_MASK);

   // byte-lane merge of a write into an existing register word
   function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : merge_sel

   // true when the address selects the mapping word of function f
   function automatic logic map_hit(input logic [7:0] adr, input int unsigned f);
      return adr == (REG_MAP_BASE + 8'(4 * f));
   endfunction : map_hit

   // qualified contacts and raw function values
   logic [NUM_IN-1:0]   qual;
   logic [NUM_FUNC-1:0] func_raw;

   // register state
   logic [NUM_IN-1:0]   map_ff [NUM_FUNC];
   logic [NUM_IN-1:0]   pol_ff [NUM_FUNC];
   logic [NUM_IN-1:0]   nxt_map [NUM_FUNC];
   logic [NUM_IN-1:0]   nxt_pol [NUM_FUNC];
   logic [NUM_FUNC-1:0] force_ff;
   logic [NUM_FUNC-1:0] nxt_force;
   logic [NUM_ELEM-1:0] trip_mask_ff;
   logic [NUM_ELEM-1:0] nxt_trip_mask;
   logic [DAY_W-1:0]    day_ff;
   logic [DAY_W-1:0]    nxt_day;
   logic                ack_ff;
   logic                nxt_ack;
   logic [31:0]         rdat_ff;
   logic [31:0]         nxt_rdat;

   // output and display state
   logic [NUM_FUNC-1:0]    func_ff;
   logic [NUM_FUNC-1:0]    nxt_func;
   logic                   trip_ff;
   logic                   nxt_trip;
   logic                   coil_alm_ff;
   logic                   nxt_coil_alm;
   logic [BLINK_CNT_W-1:0] blink_cnt_ff;
   logic [BLINK_CNT_W-1:0] nxt_blink_cnt;
   logic                   blink_on_ff;
   logic                   nxt_blink_on;

   logic                   req;
   logic                   wr;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++)
      begin : g_in
         cim_contact_qual #(
            .QUAL_CLKS_P (QUAL_CLKS_P)
         ) u_qual (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .contact_i (contact_i[gi]),
            .state_o   (qual[gi])
         );
      end
      for (gi = 0; gi < NUM_FUNC; gi++)
      begin : g_func
         // unmapped defaults: alternate select and the aux functions read zero,
         // trip coil monitor and the supervision set read one
         cim_func_eval u_eval (
            .map_i  (map_ff[gi]),
            .pol_i  (pol_ff[gi]),
            .qual_i (qual),
            .dflt_i (DFLT_ON[gi]),
            .val_o  (func_raw[gi])
         );
      end
   endgenerate

   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr  = req & wb_we_i;

   // register file next state
   always_comb
   begin
      logic [31:0] word;
      word          = '0;
      nxt_force     = force_ff;
      nxt_trip_mask = trip_mask_ff;
      nxt_day       = day_ff;
      nxt_ack       = req;
      nxt_rdat      = rdat_ff;
      for (int f = 0; f < NUM_FUNC; f++)
      begin
         nxt_map[f] = map_ff[f];
         nxt_pol[f] = pol_ff[f];
      end
      if (wr)
      begin
         if (wb_adr_i == REG_FORCE)
         begin
            word      = merge_sel(32'(force_ff), wb_dat_i, wb_sel_i);
            nxt_force = word[NUM_FUNC-1:0];
         end
         if (wb_adr_i == REG_TRIP_MASK)
         begin
            word          = merge_sel(32'(trip_mask_ff), wb_dat_i, wb_sel_i);
            nxt_trip_mask = word[NUM_ELEM-1:0];
         end
         if (wb_adr_i == REG_RTC_DAY)
         begin
            word    = merge_sel(32'(day_ff), wb_dat_i, wb_sel_i);
            nxt_day = word[DAY_W-1:0];
         end
         for (int f = 0; f < NUM_FUNC; f++)
         begin
            if (map_hit(wb_adr_i, f))
            begin
               word = merge_sel({16'h0000, 2'b00, pol_ff[f], 2'b00, map_ff[f]},
                                wb_dat_i, wb_sel_i);
               nxt_map[f] = word[MAP_LSB +: NUM_IN];
               nxt_pol[f] = word[POL_LSB +: NUM_IN];
            end
         end
      end
      if (req & ~wb_we_i)
      begin
         // unmapped offsets answer with zero rather than stalling the bus
         nxt_rdat = '0;
         if (wb_adr_i == REG_STATUS)
         begin
            nxt_rdat[STAT_IN_LSB +: NUM_IN] = qual;
            nxt_rdat[STAT_ALARM]            = coil_alm_ff;
            nxt_rdat[STAT_RTC]              = day_ff != '0;
            nxt_rdat[STAT_BLINK]            = user_display_blink_o;
         end
         if (wb_adr_i == REG_FUNC)
         begin
            nxt_rdat[NUM_FUNC-1:0] = func_ff;
         end
         if (wb_adr_i == REG_FORCE)
         begin
            nxt_rdat[NUM_FUNC-1:0] = force_ff;
         end
         if (wb_adr_i == REG_TRIP_MASK)
         begin
            nxt_rdat[NUM_ELEM-1:0] = trip_mask_ff;
         end
         if (wb_adr_i == REG_RTC_DAY)
         begin
            nxt_rdat[DAY_W-1:0] = day_ff;
         end
         for (int f = 0; f < NUM_FUNC; f++)
         begin
            if (map_hit(wb_adr_i, f))
            begin
               nxt_rdat[MAP_LSB +: NUM_IN] = map_ff[f];
               nxt_rdat[POL_LSB +: NUM_IN] = pol_ff[f];
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int f = 0; f < NUM_FUNC; f++)
         begin
            map_ff[f] <= '0;
            pol_ff[f] <= '0;
         end
         // factory mapping, closed contact enables in each case
         map_ff[F_BREAKER_CLOSED_AUX]   <= DFLT_MAP_CLOSED;
         pol_ff[F_BREAKER_CLOSED_AUX]   <= DFLT_MAP_CLOSED;
         map_ff[F_BREAKER_OPEN_AUX]     <= DFLT_MAP_OPEN;
         pol_ff[F_BREAKER_OPEN_AUX]     <= DFLT_MAP_OPEN;
         map_ff[F_RECLOSE_ENABLE_INPUT] <= DFLT_MAP_RECLOSE;
         pol_ff[F_RECLOSE_ENABLE_INPUT] <= DFLT_MAP_RECLOSE;
         force_ff     <= RST_FORCE;
         trip_mask_ff <= RST_TRIP_MASK;
         day_ff       <= RST_DAY;
         ack_ff       <= 1'b0;
         rdat_ff      <= '0;
      end
      else
      begin
         for (int f = 0; f < NUM_FUNC; f++)
         begin
            map_ff[f] <= nxt_map[f];
            pol_ff[f] <= nxt_pol[f];
         end
         force_ff     <= nxt_force;
         trip_mask_ff <= nxt_trip_mask;
         day_ff       <= nxt_day;
         ack_ff       <= nxt_ack;
         rdat_ff      <= nxt_rdat;
      end
   end

   // function values, master trip, coil alarm and message blink
   always_comb
   begin
      nxt_func      = func_raw | force_ff;
      nxt_trip      = |(elem_trip_i & trip_mask_ff);
      // the monitor only means something while the breaker reads closed
      nxt_coil_alm  = ~func_ff[F_TRIP_COIL_MONITOR] & func_ff[F_BREAKER_CLOSED_AUX];
      nxt_blink_cnt = '0;
      nxt_blink_on  = 1'b1;
      if (func_ff[F_USER_DISPLAY_INPUT])
      begin
         nxt_blink_on  = blink_on_ff;
         nxt_blink_cnt = blink_cnt_ff + 1'b1;
         if (blink_cnt_ff == BLINK_LAST)
         begin
            nxt_blink_cnt = '0;
            nxt_blink_on  = ~blink_on_ff;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         func_ff      <= '0;
         trip_ff      <= 1'b0;
         coil_alm_ff  <= 1'b0;
         blink_cnt_ff <= '0;
         blink_on_ff  <= 1'b1;
      end
      else
      begin
         func_ff      <= nxt_func;
         trip_ff      <= nxt_trip;
         coil_alm_ff  <= nxt_coil_alm;
         blink_cnt_ff <= nxt_blink_cnt;
         blink_on_ff  <= nxt_blink_on;
      end
   end

   // with the input idle the message stays steadily shown
   assign user_display_blink_o      = blink_on_ff;
   assign func_o                    = func_ff;
   assign master_trip_o             = trip_ff;
   assign trip_circuit_fail_alarm_o = coil_alm_ff;
   assign rtc_run_o                 = day_ff != '0;
   assign wb_ack_o                  = ack_ff;
   assign wb_dat_o                  = rdat_ff;

endmodule : cim_contact_input_mapper

// *** test/cim_mapper_checker.sv ***
// port-level assertions for the contact input mapper
module cim_mapper_checker
#(
   parameter bit EARTH_FITTED = 1'b1  // earth-fault variant fitted
)
(
   input wire logic                         clk_i,                      // clock
   input wire logic                         rst_i,                      // reset
   input wire logic [7:0]                   wb_adr_i,                   // address
   input wire logic [31:0]                  wb_dat_i,                   // write data
   input wire logic [31:0]                  wb_dat_o,                   // read data
   input wire logic                         wb_we_i,                    // write
   input wire logic [3:0]                   wb_sel_i,                   // lanes
   input wire logic                         wb_cyc_i,                   // cycle
   input wire logic                         wb_stb_i,                   // strobe
   input wire logic                         wb_ack_o,                   // ack
   input wire logic [cim_pkg::NUM_IN-1:0]   contact_i,                  // contacts
   input wire logic [cim_pkg::NUM_ELEM-1:0] elem_trip_i,                // trips
   input wire logic                         master_trip_o,              // master trip
   input wire logic [cim_pkg::NUM_FUNC-1:0] func_o,                     // functions
   input wire logic                         trip_circuit_fail_alarm_o,  // coil alarm
   input wire logic                         user_display_blink_o,       // blink
   input wire logic                         rtc_run_o                   // clock running
);
   timeunit 1ns;
   timeprecision 1ns;
   import cim_pkg::*;
   logic                req;
   logic [NUM_FUNC-1:0] dflt;
   assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // the earth-fault bit joins the unmapped defaults only on that variant
   assign dflt = EARTH_FITTED ? DFLT_ON_MASK : (DFLT_ON_MASK & ~EARTH_MASK);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   a_ack_answer: assert property (req |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_trip_idle: assert property (elem_trip_i == '0 |=> !master_trip_o)
      else $error("master trip without element request");
   a_trip_cause: assert property (master_trip_o |-> $past(elem_trip_i) != '0)
      else $error("master trip with no cause");
   a_coil_alarm: assert property (1'b1 |=> trip_circuit_fail_alarm_o ==
      $past(func_o[F_BREAKER_CLOSED_AUX] && !func_o[F_TRIP_COIL_MONITOR]))
      else $error("coil alarm mismatch");
   a_blink_idle: assert property (!func_o[F_USER_DISPLAY_INPUT] [*2]
      |-> user_display_blink_o)
      else $error("message not steady while display input idle");
   // sized for the short blink period used in simulation
   a_blink_runs: assert property (not ((func_o[F_USER_DISPLAY_INPUT]
      && $stable(user_display_blink_o)) [*8]))
      else $error("message not blinking");
   a_rtc_stop: assert property (req && wb_we_i && wb_adr_i == REG_RTC_DAY
      && wb_sel_i[0] && wb_dat_i[4:0] == 5'h00 |-> ##[1:2] !rtc_run_o)
      else $error("clock kept running after day zero");
   a_func_reset: assert property ($past(rst_i) |=> func_o == dflt)
      else $error("function defaults wrong after reset");
   c_write: cover property (req && wb_we_i);
   c_alarm: cover property (trip_circuit_fail_alarm_o);
   c_blink: cover property (func_o[F_USER_DISPLAY_INPUT] && !user_display_blink_o);
   c_trip: cover property (master_trip_o);
endmodule : cim_mapper_checker

// *** test/cim_contact_model.sv ***
// bouncing contact model for breaker auxiliaries and field wiring
module cim_contact_model
(
   input  wire logic [cim_pkg::NUM_IN-1:0] lvl_i,      // settled level, 1 = closed
   input  wire logic                       clk_i,      // clock
   output logic      [cim_pkg::NUM_IN-1:0] contact_o   // level at the inputs
);
   timeunit 1ns;
   timeprecision 1ns;
   import cim_pkg::*;
   logic [NUM_IN-1:0] prev_ff = '0;
   logic [NUM_IN-1:0] chg_ff  = '0;
   logic [1:0]        cnt_ff  = 2'h0;
   logic              ph_ff   = 1'b0;
   // real contacts chatter after each operation, so the qualifier never sees clean edges
   always @(posedge clk_i)
   begin
      prev_ff <= lvl_i;
      ph_ff   <= ~ph_ff;
      if (lvl_i != prev_ff)
      begin
         chg_ff <= lvl_i ^ prev_ff;
         cnt_ff <= 2'h3;
      end
      else if (cnt_ff != 2'h0)
         cnt_ff <= cnt_ff - 2'h1;
   end
   assign contact_o = (cnt_ff != 2'h0) ? (lvl_i ^ (chg_ff & {NUM_IN{ph_ff}})) : lvl_i;
endmodule : cim_contact_model

// *** test/tb.sv ***
// self-checking bench for the contact input mapper
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cim_pkg::*;
   localparam int QUAL = 8;
   localparam int WQ   = 20;  // qualify time plus bounce and pipeline
   typedef struct packed {logic [4:0] f; logic [5:0] map, pol, lvl; logic e;} cim_row_t;
   cim_row_t rows [12] = '{
      '{5'h00, 6'h01, 6'h01, 6'h01, 1'b1}, '{5'h00, 6'h01, 6'h01, 6'h00, 1'b0},
      '{5'h01, 6'h02, 6'h02, 6'h02, 1'b1}, '{5'h01, 6'h02, 6'h02, 6'h00, 1'b0},
      '{5'h02, 6'h04, 6'h04, 6'h04, 1'b1}, '{5'h05, 6'h08, 6'h00, 6'h00, 1'b1},
      '{5'h05, 6'h08, 6'h00, 6'h08, 1'b0}, '{5'h0a, 6'h30, 6'h30, 6'h10, 1'b0},
      '{5'h0a, 6'h30, 6'h30, 6'h30, 1'b1}, '{5'h0c, 6'h00, 6'h00, 6'h3f, 1'b0},
      '{5'h04, 6'h00, 6'h00, 6'h00, 1'b1}, '{5'h10, 6'h20, 6'h20, 6'h20, 1'b1}};
   logic                clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, master_trip_o;
   logic                coil_alm, blink, rtc_run;
   logic [7:0]          wb_adr_i;
   logic [31:0]         wb_dat_i, wb_dat_o, v;
   logic [3:0]          wb_sel_i;
   logic [NUM_IN-1:0]   lvl, contact_i;
   logic [NUM_ELEM-1:0] elem_trip_i;
   logic [NUM_FUNC-1:0] func_o;
   int                  err_total  = 0;
   int                  n_compared = 0;
   always #20 clk_i = ~clk_i;
   cim_contact_model i_cim_contact_model (.lvl_i(lvl), .clk_i(clk_i), .contact_o(contact_i));
   cim_contact_input_mapper #(.QUAL_CLKS_P(QUAL), .BLINK_CLKS_P(4), .EARTH_FITTED(1'b1))
   i_cim_contact_input_mapper (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .contact_i(contact_i),
      .elem_trip_i(elem_trip_i), .master_trip_o(master_trip_o), .func_o(func_o),
      .trip_circuit_fail_alarm_o(coil_alm), .user_display_blink_o(blink), .rtc_run_o(rtc_run));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      check({31'h0, wb_ack_o}, 32'h1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] t;
      xfer(1'b1, a, d, 4'hf, t);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] t;
      xfer(1'b0, a, 32'h0, 4'hf, t);
      check(t, e);
   endtask : rdchk
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   initial
   begin
      #(40 * 8000);
      err_total++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_sim();
   end
   initial
   begin
      {clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
      rst_i = 1'b1;
      lvl = '0;
      elem_trip_i = '0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(REG_TRIP_MASK, 32'h0000ffff);
      rdchk(REG_RTC_DAY, 32'h00000001);
      rdchk(REG_FORCE, 32'h00000000);
      rdchk(REG_MAP_BASE, 32'h00000101);
      rdchk(REG_MAP_BASE + 8'h04, 32'h00000202);
      wr(REG_FUNC, 32'h00000000);
      wr(8'h20, 32'hffffffff);
      rdchk(8'h20, 32'h00000000);
      rdchk(REG_FUNC, {15'h0000, DFLT_ON_MASK});
      check({30'h0, rtc_run, blink}, 32'h3);
      foreach (rows[i])
      begin
         wr(REG_MAP_BASE + {1'b0, rows[i].f, 2'b00}, {18'h0, rows[i].pol, 2'b00, rows[i].map});
         lvl <= rows[i].lvl;
         repeat (WQ) @(posedge clk_i);
         xfer(1'b0, REG_STATUS, 32'h0, 4'hf, v);
         check({26'h0, v[5:0]}, {26'h0, rows[i].lvl});
         check({31'h0, func_o[rows[i].f]}, {31'h0, rows[i].e});
      end
      wr(REG_MAP_BASE + 8'h40, 32'h00000000);
      lvl <= 6'h00;
      repeat (WQ) @(posedge clk_i);
      // a pulse shorter than the qualify time, bounce included, must vanish
      lvl <= 6'h01;
      repeat (5) @(posedge clk_i);
      lvl <= 6'h00;
      repeat (WQ) @(posedge clk_i);
      check({31'h0, func_o[0]}, 32'h0);
      lvl <= 6'h01;
      repeat (QUAL) @(posedge clk_i);
      check({31'h0, func_o[0]}, 32'h0);
      repeat (WQ) @(posedge clk_i);
      check({31'h0, func_o[0]}, 32'h1);
      wr(REG_MAP_BASE + 8'h24, 32'h00000808);
      repeat (4) @(posedge clk_i);
      check({31'h0, coil_alm}, 32'h1);
      rdchk(REG_STATUS, 32'h00000701);
      lvl <= 6'h09;
      repeat (WQ) @(posedge clk_i);
      check({31'h0, coil_alm}, 32'h0);
      wr(REG_FORCE, 32'h00001000);
      repeat (3) @(posedge clk_i);
      check({31'h0, func_o[F_ALT_SETTINGS_ONE]}, 32'h1);
      rdchk(REG_FORCE, 32'h00001000);
      wr(REG_FORCE, 32'h00000000);
      xfer(1'b1, REG_TRIP_MASK, 32'h0000ab01, 4'h1, v);
      rdchk(REG_TRIP_MASK, 32'h0000ff01);
      elem_trip_i <= 16'h0002;
      repeat (3) @(posedge clk_i);
      check({31'h0, master_trip_o}, 32'h0);
      elem_trip_i <= 16'h0001;
      repeat (3) @(posedge clk_i);
      check({31'h0, master_trip_o}, 32'h1);
      wr(REG_RTC_DAY, 32'h00000000);
      repeat (2) @(posedge clk_i);
      check({31'h0, rtc_run}, 32'h0);
      wr(REG_RTC_DAY, 32'h00000005);
      repeat (2) @(posedge clk_i);
      check({31'h0, rtc_run}, 32'h1);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(REG_TRIP_MASK, 32'h0000ffff);
      end_sim();
   end
endmodule : tb
bind cim_contact_input_mapper cim_mapper_checker #(.EARTH_FITTED(EARTH_FITTED))
i_cim_mapper_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .contact_i(contact_i), .elem_trip_i(elem_trip_i),
   .master_trip_o(master_trip_o), .func_o(func_o),
   .trip_circuit_fail_alarm_o(trip_circuit_fail_alarm_o),
   .user_display_blink_o(user_display_blink_o), .rtc_run_o(rtc_run_o));
